// ---- hdl/pbs_top.sv ----
// Push-button power sequencer core
`timescale 1ns/1ps
`default_nettype none
module pbs_top
  import pbs_pkg::*;
#(
  parameter int DEBOUNCE_CNT    = DEBOUNCE_CYC,
  parameter int LONG_PUSH_CNT   = LONG_PUSH_CYC,
  parameter int CONFIRM_CNT     = CONFIRM_CYC,
  parameter int RESET_PULSE_CNT = RESET_PULSE_CYC,
  parameter int IRQ_MIN_CNT     = IRQ_MIN_CYC,
  parameter bit LONG_PUSH_RESET = 1'b0,
  parameter bit HOLD_TO_START   = 1'b0
) (
  input  wire logic MCLK,
  input  wire logic RESET_N,
  input  wire logic POWER_BUTTON_N,
  input  wire logic SECOND_BUTTON_N,
  input  wire logic PROCESSOR_ACK,
  input  wire logic SUPPLY_OK,
  output logic      SUPPLY_ON,
  output logic      RESET_OUT_N,
  output logic      IRQ_N,
  output logic      ACK_PULLDOWN,
  output logic      REF_ENABLE,
  output logic      UNDERVOLTAGE_FLAG_N,
  output logic      BUTTON_STATE_N
);
  typedef struct packed {
    logic [1:0]       pb_s;
    logic [1:0]       sb_s;
    logic [1:0]       ack_s;
    logic [1:0]       sup_s;
    pbs_state_e       st;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] rst_cnt;
    logic [CNT_W-1:0] irq_cnt;
    logic [CNT_W-1:0] lp_cnt;
    logic             rst_act;
    logic             irq_act;
    logic             irq_btn;
    logic             ref_en;
    logic             on;
    logic             btn_out;
  } pbs_s;

  pbs_s        r_q;
  pbs_s        r_d;
  logic [1:0]  rsync_q;
  logic        rst_n;
  logic        pb;
  logic        sb;
  logic        ack;
  logic        sup;
  logic        long_hit;

  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  assign pb  = ~r_q.pb_s[1];
  assign sb  = ~r_q.sb_s[1];
  assign ack = r_q.ack_s[1];
  assign sup = r_q.sup_s[1];
  assign long_hit = pb && sb && (r_q.lp_cnt >= CNT_W'(LONG_PUSH_CNT - 1));

  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    return v + CNT_W'(1);
  endfunction

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    r_d = r_q;
    r_d.pb_s  = {r_q.pb_s[0], POWER_BUTTON_N};
    r_d.sb_s  = {r_q.sb_s[0], SECOND_BUTTON_N};
    r_d.ack_s = {r_q.ack_s[0], PROCESSOR_ACK};
    r_d.sup_s = {r_q.sup_s[0], SUPPLY_OK};
    r_d.tmr   = inc(r_q.tmr);
    // Long push counter only runs while both buttons are held
    r_d.lp_cnt = (pb && sb && r_q.st == PBS_NORMAL) ? inc(r_q.lp_cnt) : CNT_RESET;
    // Reset pulse
    if (r_q.rst_act) begin
      r_d.rst_cnt = inc(r_q.rst_cnt);
      if (r_q.rst_cnt >= CNT_W'(RESET_PULSE_CNT - 1)) begin
        r_d.rst_act = 1'b0;
        r_d.ref_en  = 1'b1;
      end
    end
    // Interrupt minimum hold, extended by held button (button irq) or by low supply (undervoltage irq)
    if (r_q.irq_act) begin
      r_d.irq_cnt = inc(r_q.irq_cnt);
      if (r_q.irq_cnt >= CNT_W'(IRQ_MIN_CNT - 1) && !(r_q.irq_btn && pb)
          && !(!r_q.irq_btn && !sup)) begin
        r_d.irq_act = 1'b0;
      end
    end
    if (r_q.btn_out && !pb && !r_q.irq_act) begin
      r_d.btn_out = 1'b0;
    end
    unique case (r_q.st)
      PBS_STANDBY: begin
        r_d.on = 1'b0;
        r_d.ref_en = 1'b0;
        r_d.rst_act = 1'b0;
        r_d.irq_act = 1'b0;
        r_d.btn_out = 1'b0;
        r_d.tmr = CNT_RESET;
        if (pb) begin
          r_d.st = PBS_DEBOUNCE;
        end
      end
      PBS_DEBOUNCE: begin
        r_d.btn_out = 1'b1;
        if (!pb) begin
          r_d.st = PBS_STANDBY;
        end else if (!sup) begin
          r_d.tmr = CNT_RESET;
        end else if (r_q.tmr >= CNT_W'(DEBOUNCE_CNT - 1)) begin
          r_d.on = 1'b1;
          r_d.rst_act = 1'b1;
          r_d.rst_cnt = CNT_RESET;
          r_d.irq_cnt = CNT_RESET;
          r_d.tmr = CNT_RESET;
          r_d.st = PBS_WAIT;
        end
      end
      PBS_WAIT: begin
        if (ack) begin
          r_d.st = PBS_NORMAL;
        end else if (r_q.tmr >= CNT_W'(CONFIRM_CNT - 1)) begin
          r_d.st = PBS_POWERDN;
        end else if (HOLD_TO_START && !pb) begin
          r_d.st = PBS_POWERDN;
        end
      end
      PBS_NORMAL: begin
        if (!ack) begin
          r_d.st = PBS_POWERDN;
        end else if (long_hit) begin
          if (LONG_PUSH_RESET) begin
            r_d.rst_act = 1'b1;
            r_d.rst_cnt = CNT_RESET;
            r_d.ref_en = 1'b0;
            r_d.tmr = CNT_RESET;
            r_d.st = PBS_WAIT;
          end else begin
            r_d.st = PBS_POWERDN;
          end
        end else if (!r_q.irq_act && !sup) begin
          r_d.irq_act = 1'b1;
          r_d.irq_btn = 1'b0;
          r_d.irq_cnt = CNT_RESET;
        end else if (!r_q.irq_act && pb && r_q.tmr >= CNT_W'(DEBOUNCE_CNT - 1)) begin
          r_d.irq_act = 1'b1;
          r_d.irq_btn = 1'b1;
          r_d.btn_out = 1'b1;
          r_d.irq_cnt = CNT_RESET;
        end
        // Debounce timer for short press reuses tmr while button held
        if (!pb || r_q.irq_act) begin
          r_d.tmr = CNT_RESET;
        end
      end
      PBS_POWERDN: begin
        r_d.on = 1'b0;
        if (!pb && !sb) begin
          r_d.st = PBS_STANDBY;
        end
      end
      default: r_d.st = PBS_STANDBY;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{pb_s: 2'h3, sb_s: 2'h3, ack_s: 2'h0, sup_s: 2'h0, st: PBS_STANDBY,
               tmr: CNT_RESET, rst_cnt: CNT_RESET, irq_cnt: CNT_RESET,
               lp_cnt: CNT_RESET, default: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign SUPPLY_ON    = r_q.on;
  assign RESET_OUT_N  = ~r_q.rst_act;
  assign IRQ_N        = ~r_q.irq_act;
  assign ACK_PULLDOWN = (r_q.st == PBS_DEBOUNCE) || (r_q.st == PBS_WAIT);
  assign REF_ENABLE   = r_q.ref_en;
  assign UNDERVOLTAGE_FLAG_N = (r_q.st == PBS_STANDBY) ? 1'b1 : r_q.sup_s[1];
  assign BUTTON_STATE_N = ~r_q.btn_out;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_rst_start;
    $rose(r_q.rst_act);
  endsequence
  property p_on_needs_supply;
    @(posedge MCLK) disable iff (!rst_n) $rose(SUPPLY_ON) |-> $past(sup);
  endproperty
  a_on_needs_supply: assert property (p_on_needs_supply) else $error("on without supply");
  property p_irq_normal;
    @(posedge MCLK) disable iff (!rst_n) $fell(IRQ_N) |-> $past(r_q.st) == PBS_NORMAL;
  endproperty
  a_irq_normal: assert property (p_irq_normal) else $error("irq outside normal");
  property p_ref_after_rst;
    @(posedge MCLK) disable iff (!rst_n) $rose(REF_ENABLE) |-> $rose(RESET_OUT_N);
  endproperty
  a_ref_after_rst: assert property (p_ref_after_rst) else $error("ref early");
  property p_standby_off;
    @(posedge MCLK) disable iff (!rst_n)
      (r_q.st == PBS_STANDBY) [*2] |-> !SUPPLY_ON && !REF_ENABLE && IRQ_N;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("standby outputs");
  property p_ack_low_off;
    @(posedge MCLK) disable iff (!rst_n)
      (r_q.st == PBS_NORMAL && !ack) |=> ##1 !SUPPLY_ON;
  endproperty
  a_ack_low_off: assert property (p_ack_low_off) else $error("ack low kept on");
  property p_pulldown;
    @(posedge MCLK) disable iff (!rst_n) $rose(SUPPLY_ON) |-> ACK_PULLDOWN && !REF_ENABLE;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown missing at start");
  property p_rst_start;
    @(posedge MCLK) disable iff (!rst_n) s_rst_start |-> !RESET_OUT_N [*2];
  endproperty
  a_rst_start: assert property (p_rst_start) else $error("reset pulse short");
  property p_wait_ack;
    @(posedge MCLK) disable iff (!rst_n) (r_q.st == PBS_WAIT && ack) |=> r_q.st == PBS_NORMAL;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("ack not confirmed");
endmodule
`default_nettype wire

// ---- common/pbs_pkg.sv ----
// Constants and types for the push-button power sequencer
package pbs_pkg;
  localparam int CLK_HZ           = 50_000_000;
  localparam int DEBOUNCE_MS      = 30;
  localparam int LONG_PUSH_MS     = 2000;
  localparam int CONFIRM_MS       = 1000;
  localparam int RESET_PULSE_MS   = 200;
  localparam int IRQ_MIN_MS       = 100;
  localparam int DEBOUNCE_CYC     = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int LONG_PUSH_CYC    = CLK_HZ / 1000 * LONG_PUSH_MS;
  localparam int CONFIRM_CYC      = CLK_HZ / 1000 * CONFIRM_MS;
  localparam int RESET_PULSE_CYC  = CLK_HZ / 1000 * RESET_PULSE_MS;
  localparam int IRQ_MIN_CYC      = CLK_HZ / 1000 * IRQ_MIN_MS;
  localparam int CNT_W            = 32;
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0;

  typedef enum logic [2:0] {
    PBS_STANDBY  = 3'b000,
    PBS_DEBOUNCE = 3'b001,
    PBS_WAIT     = 3'b011,
    PBS_NORMAL   = 3'b010,
    PBS_POWERDN  = 3'b110
  } pbs_state_e;
endpackage

// ---- verif/pbs_host_model.sv ----
// Host processor model that drives the power confirmation line
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model #(
  parameter int ACK_DLY = 12
) (
  input  wire logic mclk,
  input  wire logic supply_on,
  input  wire logic ack_en,
  output logic      ack_oe,
  output logic      ack_val
);
  int   cnt   = 0;
  logic oe_q  = 1'b0;
  logic val_q = 1'b0;
  assign ack_oe  = oe_q;
  assign ack_val = val_q;
  // ****************************************
  // Confirmation and shutdown request
  // ****************************************
  // Stays high-Z until booted, so only the weak pull sets the line early
  always @(posedge mclk) begin
    if (!supply_on) begin
      cnt <= 0;
      oe_q <= 1'b0;
    end else if (cnt < ACK_DLY) begin
      cnt <= cnt + 1;
    end else if (ack_en || oe_q) begin
      oe_q <= 1'b1;
    end
    val_q <= ack_en;
  end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the push-button power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pbs_pkg::*;
  localparam int DB = 8;
  localparam int LP = 20;
  localparam int CW = 30;
  localparam int RP = 5;
  localparam int IM = 6;
  typedef struct {logic sup; logic ack; int hold; logic on; logic on_alt;} pbs_row_s;
  // The alternate build needs the button held until the host confirms
  pbs_row_s rows [4] = '{'{1'b1, 1'b1, DB + 6, 1'b1, 1'b0},
                         '{1'b0, 1'b1, DB + 6, 1'b0, 1'b0},
                         '{1'b1, 1'b0, DB + 6, 1'b0, 1'b0},
                         '{1'b1, 1'b1, DB + CW, 1'b1, 1'b1}};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic pb_n = 1'b1;
  logic sb_n = 1'b1;
  logic sup_ok = 1'b1;
  logic ack_en = 1'b1;
  logic flt = 1'b0;
  logic ack_oe, ack_val, ack_w, sup_on, rst_n_o, irq_n, ack_pd, ref_en, uv_n;
  logic ack_oe2, ack_val2, ack_w2, sup_on2, rst_n_o2, ack_pd2, ref_en2, btn_n;
  int   err_count = 0;
  int   checks = 0;
  int   cyc = 0;
  always #10 mclk = ~mclk;
  // An undriven, unpulled line must not read as a steady level
  always @(posedge mclk) flt <= ~flt;
  assign ack_w = ack_oe ? ack_val : (ack_pd ? 1'b0 : flt);
  pbs_top #(.DEBOUNCE_CNT(DB), .LONG_PUSH_CNT(LP), .CONFIRM_CNT(CW),
    .RESET_PULSE_CNT(RP), .IRQ_MIN_CNT(IM)) u_dut (
    .MCLK(mclk), .RESET_N(reset_n), .POWER_BUTTON_N(pb_n), .SECOND_BUTTON_N(sb_n),
    .PROCESSOR_ACK(ack_w), .SUPPLY_OK(sup_ok), .SUPPLY_ON(sup_on),
    .RESET_OUT_N(rst_n_o), .IRQ_N(irq_n), .ACK_PULLDOWN(ack_pd), .REF_ENABLE(ref_en),
    .UNDERVOLTAGE_FLAG_N(uv_n), .BUTTON_STATE_N(btn_n));
  pbs_host_model u_host (.mclk(mclk), .supply_on(sup_on), .ack_en(ack_en),
    .ack_oe(ack_oe), .ack_val(ack_val));
  // Second build: long push pulses reset, power needs the button held to start
  assign ack_w2 = ack_oe2 ? ack_val2 : (ack_pd2 ? 1'b0 : flt);
  pbs_top #(.DEBOUNCE_CNT(DB), .LONG_PUSH_CNT(LP), .CONFIRM_CNT(CW),
    .RESET_PULSE_CNT(RP), .IRQ_MIN_CNT(IM), .LONG_PUSH_RESET(1'b1),
    .HOLD_TO_START(1'b1)) u_dut_alt (
    .MCLK(mclk), .RESET_N(reset_n), .POWER_BUTTON_N(pb_n), .SECOND_BUTTON_N(sb_n),
    .PROCESSOR_ACK(ack_w2), .SUPPLY_OK(sup_ok), .SUPPLY_ON(sup_on2),
    .RESET_OUT_N(rst_n_o2), .IRQ_N(), .ACK_PULLDOWN(ack_pd2), .REF_ENABLE(ref_en2),
    .UNDERVOLTAGE_FLAG_N(), .BUTTON_STATE_N());
  pbs_host_model u_host_alt (.mclk(mclk), .supply_on(sup_on2), .ack_en(ack_en),
    .ack_oe(ack_oe2), .ack_val(ack_val2));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    cyc_n(2);
    reset_n = 1'b1;
    cyc_n(4);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      sup_ok = rows[i].sup;
      ack_en = rows[i].ack;
      do_reset();
      chk(sup_on, 1'b0, "enable after reset");
      chk(rst_n_o, 1'b1, "reset out after reset");
      pb_n = 1'b0;
      cyc_n(rows[i].hold);
      pb_n = 1'b1;
      cyc_n(CW + 10);
      chk(sup_on, rows[i].on, "power-up outcome");
      chk(sup_on2, rows[i].on_alt, "hold-to-start outcome");
    end
    sup_ok = 1'b1;
    ack_en = 1'b1;
    do_reset();
    pb_n = 1'b0;
    for (int k = 0; k < 40 && sup_on !== 1'b1; k++) cyc_n(1);
    chk(rst_n_o, 1'b0, "reset pulse at start");
    chk(ack_pd, 1'b1, "ack pull in startup");
    chk(ref_en, 1'b0, "ref during reset");
    pb_n = 1'b1;
    cyc_n(RP + 4);
    chk(rst_n_o, 1'b1, "reset pulse end");
    chk(ref_en, 1'b1, "ref after reset");
    cyc_n(CW);
    chk(ack_pd, 1'b0, "ack pull in normal");
    chk(irq_n, 1'b1, "no irq at start");
    pb_n = 1'b0;
    cyc_n(DB + IM + 6);
    chk(irq_n, 1'b0, "irq while held");
    chk(btn_n, 1'b0, "button state on press irq");
    pb_n = 1'b1;
    cyc_n(IM + 6);
    chk(irq_n, 1'b1, "irq end");
    chk(btn_n, 1'b1, "button state after release");
    pb_n = 1'b0;
    cyc_n(DB + 4);
    pb_n = 1'b1;
    cyc_n(3);
    chk(irq_n, 1'b0, "irq minimum time");
    cyc_n(IM + 6);
    sup_ok = 1'b0;
    cyc_n(5);
    chk(irq_n, 1'b0, "undervoltage irq");
    chk(uv_n, 1'b0, "undervoltage flag");
    chk(btn_n, 1'b1, "button state on undervoltage irq");
    sup_ok = 1'b1;
    cyc_n(IM + 6);
    chk(sup_on, 1'b1, "short dip keeps power");
    chk(uv_n, 1'b1, "undervoltage flag end");
    chk(irq_n, 1'b1, "undervoltage irq end");
    pb_n = 1'b0;
    sb_n = 1'b0;
    cyc_n(LP - 4);
    chk(sup_on, 1'b1, "long push too early");
    cyc_n(DB + 12);
    pb_n = 1'b1;
    sb_n = 1'b1;
    cyc_n(6);
    chk(sup_on, 1'b0, "long push off");
    do_reset();
    pb_n = 1'b0;
    cyc_n(DB + 6);
    pb_n = 1'b1;
    cyc_n(CW);
    ack_en = 1'b0;
    cyc_n(8);
    chk(sup_on, 1'b0, "ack low shuts down");
    chk(ref_en, 1'b0, "ref off in standby");
    // Long push on the reset-option build, button held through start-up
    ack_en = 1'b1;
    do_reset();
    pb_n = 1'b0;
    cyc_n(CW);
    chk(sup_on2, 1'b1, "hold-to-start power-up");
    sb_n = 1'b0;
    cyc_n(LP + 4);
    chk(rst_n_o2, 1'b0, "long push reset pulse");
    chk(sup_on2, 1'b1, "long push reset keeps power");
    chk(ref_en2, 1'b0, "ref off during long push reset");
    pb_n = 1'b1;
    sb_n = 1'b1;
    cyc_n(RP + 4);
    chk(rst_n_o2, 1'b1, "long push reset end");
    chk(ref_en2, 1'b1, "ref back after reset");
    print_verdict();
  end
endmodule
`default_nettype wire
